//--- logic/cvo_pkg.sv
package cvo_pkg;

  // ******************************
  // Video timing
  // ******************************
  localparam int unsigned PIX_HZ   = 20034000;
  localparam int unsigned FRAME_HZ = 15;
  localparam int unsigned H_ACT    = 1024;
  localparam int unsigned V_ACT    = 1024;
  localparam int unsigned H_TOTAL  = 1300;
  // Lines per frame chosen so the frame rate lands on FRAME_HZ
  localparam int unsigned V_TOTAL  = PIX_HZ / (FRAME_HZ * H_TOTAL);
  localparam int unsigned HD_WIDTH = 64;
  localparam int unsigned DATA_W   = 10;

  // ******************************
  // Panel selector codes
  // ******************************
  localparam logic [3:0] MODE_NORMAL  = 4'h0;
  localparam logic [3:0] MODE_GAIN    = 4'h1;
  localparam logic [3:0] MODE_SHUT    = 4'h2;
  localparam logic [3:0] MODE_PRE_LO  = 4'h3;
  localparam logic [3:0] MODE_PRE_HI  = 4'h4;
  localparam logic [3:0] MODE_CLOCK   = 4'h5;
  localparam logic [3:0] MODE_FREEZE  = 4'h8;
  localparam logic [3:0] MODE_FACTORY = 4'h9;
  localparam logic [3:0] MODE_PAGE_A  = 4'ha;

  // ******************************
  // Gain in dB
  // ******************************
  localparam logic [4:0] GAIN_MIN_DB  = 5'h06;
  localparam logic [4:0] GAIN_MAX_DB  = 5'h16;
  localparam logic [4:0] GAIN_STEP_DB = 5'h01;
  localparam logic [4:0] PRE_3UP_DB   = 5'h06;
  localparam logic [4:0] PRE_3DN_DB   = 5'h09;
  localparam logic [4:0] PRE_4UP_DB   = 5'h0c;
  localparam logic [4:0] PRE_4DN_DB   = 5'h10;

  localparam logic [1:0] BOOT_WAIT = 2'h3;

  // Pixel rate: full, half, quarter of the standard rate
  typedef enum logic [1:0] {
    DIV_1 = 2'h0,
    DIV_2 = 2'h1,
    DIV_4 = 2'h2
  } cvo_div_t;

  typedef struct packed {
    logic [4:0] gain;
    cvo_div_t   div;
    logic       async_sel;
    logic       freeze;
  } cvo_par_t;

  localparam cvo_par_t FACTORY_PAR = '{gain: GAIN_MIN_DB, div: DIV_1,
                                       async_sel: 1'h0, freeze: 1'h0};

  typedef enum logic [3:0] {
    ST_LIVE  = 4'b0001,
    ST_WAIT  = 4'b0010,
    ST_EXPOSURE_CONTROL_IN = 4'b0100,
    ST_HOLD  = 4'b1000
  } cvo_state_t;

endpackage : cvo_pkg

//--- logic/cvo_capture.sv
`timescale 1ns/1ps
module cvo_capture
  import cvo_pkg::*;
#(
  parameter int unsigned H_TOTAL_P   = cvo_pkg::H_TOTAL,
  parameter int unsigned V_TOTAL_P   = cvo_pkg::V_TOTAL,
  parameter int unsigned H_ACT_P     = cvo_pkg::H_ACT,
  parameter int unsigned V_ACT_P     = cvo_pkg::V_ACT,
  parameter logic [4:0]  GAIN_MAX_P  = cvo_pkg::GAIN_MAX_DB
) (
  input  wire logic                       mclk_i,
  input  wire logic                       reset_n_i,
  input  wire logic                       ce_i,
  input  wire logic                       pix_clk_i,
  input  wire logic                       async_reset_pulse_i,
  input  wire logic                       exposure_control_in_i,
  input  wire logic                       freeze_select_i,
  input  wire logic [3:0]                 mode_sel_i,
  input  wire logic                       press_up_i,
  input  wire logic                       press_down_i,
  input  wire logic                       page_store_i,
  input  wire logic [3:0]                 shutter_speed_i,
  input  wire logic [cvo_pkg::DATA_W-1:0] sensor_data_i,
  output logic                            pixel_clk_o,
  output logic [cvo_pkg::DATA_W-1:0]      pixel_data_o,
  output logic                            line_valid_o,
  output logic                            frame_valid_o,
  output logic                            horizontal_drive_o,
  output logic                            vertical_drive_o,
  output logic                            discharge_o,
  output logic [4:0]                      gain_db_o,
  output logic [3:0]                      shutter_speed_o
);
  import cvo_pkg::*;

  localparam int unsigned HW = $clog2(H_TOTAL_P);
  localparam int unsigned VW = $clog2(V_TOTAL_P);
  localparam int unsigned MD = H_ACT_P * V_ACT_P;
  localparam int unsigned AW = $clog2(MD);
  localparam logic [HW-1:0] H_LAST = HW'(H_TOTAL_P - 1);
  localparam logic [VW-1:0] V_LAST = VW'(V_TOTAL_P - 1);
  localparam logic [HW-1:0] H_ACTV = HW'(H_ACT_P);
  localparam logic [VW-1:0] V_ACTV = VW'(V_ACT_P);
  localparam logic [HW-1:0] H_DRV  = HW'(HD_WIDTH);

  function automatic logic user_page(input logic [3:0] m);
    user_page = (m >= MODE_PAGE_A);
  endfunction : user_page

  // ******************************
  // Panel domain (mclk_i)
  // ******************************
  typedef struct packed {
    logic [2:0]            up;
    logic [2:0]            dn;
    logic [2:0]            sv;
    logic [3:0]            mode_s1;
    logic [3:0]            mode_s2;
    logic [3:0]            shut_s1;
    logic [3:0]            shut_s2;
    logic [1:0]            boot;
    logic                  booted;
    cvo_par_t              par;
    cvo_par_t [15:0]       pages;
    logic [3:0]            shut;
    logic [3:0]            lvl;
  } cvo_ctl_t;

  cvo_ctl_t c;
  cvo_ctl_t next_c;
  logic     up_p;
  logic     dn_p;
  logic     live;

  always_comb begin
    next_c = c;
    up_p   = c.up[1] & ~c.up[2];
    dn_p   = c.dn[1] & ~c.dn[2];
    live   = (c.mode_s2 == MODE_NORMAL);
    next_c.up      = {c.up[1:0], press_up_i};
    next_c.dn      = {c.dn[1:0], press_down_i};
    next_c.sv      = {c.sv[1:0], page_store_i};
    next_c.mode_s1 = mode_sel_i;
    next_c.mode_s2 = c.mode_s1;
    next_c.shut_s1 = shutter_speed_i;
    next_c.shut_s2 = c.shut_s1;
    if (!c.booted) begin
      // Wait for the selector to settle through its synchroniser
      next_c.boot = c.boot + 2'h1;
      if (c.boot == BOOT_WAIT) begin
        next_c.booted = 1'h1;
        if (c.mode_s2 == MODE_FACTORY) begin
          next_c.par = FACTORY_PAR;
        end else if (user_page(c.mode_s2)) begin
          next_c.par = c.pages[c.mode_s2];
        end else begin
          next_c.par = c.pages[MODE_PAGE_A];
        end
      end
    end else begin
      case (c.mode_s2)
        MODE_GAIN: begin
          if (up_p && c.par.gain < GAIN_MAX_P) begin
            next_c.par.gain = c.par.gain + GAIN_STEP_DB;
          end
          if (dn_p && c.par.gain > GAIN_MIN_DB) begin
            next_c.par.gain = c.par.gain - GAIN_STEP_DB;
          end
        end
        MODE_SHUT: begin
          if (up_p) next_c.par.async_sel = 1'h0;
          if (dn_p) next_c.par.async_sel = 1'h1;
        end
        MODE_PRE_LO: begin
          if (up_p) next_c.par.gain = PRE_3UP_DB;
          if (dn_p) next_c.par.gain = PRE_3DN_DB;
        end
        MODE_PRE_HI: begin
          if (up_p) next_c.par.gain = PRE_4UP_DB;
          if (dn_p) next_c.par.gain = PRE_4DN_DB;
        end
        MODE_CLOCK: begin
          if (up_p && c.par.div != DIV_1) begin
            next_c.par.div = cvo_div_t'(c.par.div - 2'h1);
          end
          if (dn_p && c.par.div != DIV_4) begin
            next_c.par.div = cvo_div_t'(c.par.div + 2'h1);
          end
        end
        MODE_FREEZE: begin
          if (up_p) next_c.par.freeze = 1'h0;
          if (dn_p) next_c.par.freeze = 1'h1;
        end
        MODE_FACTORY: begin
          if (up_p) next_c.par = FACTORY_PAR;
        end
        default: begin
          if (c.sv[1] && !c.sv[2] && user_page(c.mode_s2)) begin
            next_c.pages[c.mode_s2] = c.par;
          end
        end
      endcase
    end
    // Mode 0 overrides shutter and freeze without losing stored choices
    next_c.shut = live ? 4'h0 : c.shut_s2;
    next_c.lvl  = {c.par.div, c.par.freeze & ~live,
                   c.par.async_sel & ~live};
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      c       <= '0;
      c.pages <= {16{FACTORY_PAR}};
      c.par   <= FACTORY_PAR;
    end else if (ce_i) begin
      c <= next_c;
    end
  end

  assign gain_db_o       = c.par.gain;
  assign shutter_speed_o = c.shut;

  // ******************************
  // Link domain (pix_clk_i)
  // ******************************
  // Mode levels cross as a group; they change only by panel presses and selector moves,
  // so a one-cycle skew between bits is harmless.
  typedef struct packed {
    logic [1:0]            ce;
    logic [3:0]            lv1;
    logic [3:0]            lv2;
    logic [2:0]            rp;
    logic [2:0]            ex;
    logic [1:0]            fs;
    logic [2:0]            dc;
    logic                  pclk;
    logic [HW-1:0]         h;
    logic [VW-1:0]         v;
    cvo_state_t            st;
    logic                  have;
    logic                  got;
    logic                  pend;
    logic                  cap;
    logic [AW-1:0]         addr;
    logic [DATA_W-1:0]     data;
    logic                  lv;
    logic                  fv;
    logic                  hd;
    logic                  vd;
    logic                  dis;
  } cvo_px_t;

  cvo_px_t           p;
  cvo_px_t           next_p;
  logic              tick;
  logic              wr;
  logic              async_shutter_select;
  logic              frz;
  logic              lnact;
  logic              src_mem;
  logic              vid;
  logic [2:0]        half;
  cvo_state_t        base;
  logic [DATA_W-1:0] mem [MD];
  logic [DATA_W-1:0] mem_rd;

  assign mem_rd = mem[p.addr];

  always_comb begin
    next_p  = p;
    tick    = 1'h0;
    wr      = 1'h0;
    async_shutter_select     = p.lv2[0];
    frz     = p.lv2[1] & ~p.lv2[0];
    lnact   = (p.h < H_ACTV) && (p.v < V_ACTV);
    src_mem = (p.st == ST_HOLD) && !p.cap;
    vid     = p.cap | (p.st == ST_LIVE) | ((p.st == ST_HOLD) & p.have);
    unique case (cvo_div_t'(p.lv2[3:2]))
      DIV_2:   half = 3'h1;
      DIV_4:   half = 3'h3;
      default: half = 3'h0;
    endcase
    next_p.ce  = {p.ce[0], ce_i};
    next_p.lv1 = c.lvl;
    next_p.lv2 = p.lv1;
    next_p.rp  = {p.rp[1:0], async_reset_pulse_i};
    next_p.ex  = {p.ex[1:0], exposure_control_in_i};
    next_p.fs  = {p.fs[0], freeze_select_i};
    if (!async_shutter_select && !frz) begin
      base = ST_LIVE;
    end else if (async_shutter_select) begin
      base = p.got ? ST_HOLD : ST_WAIT;
    end else begin
      base = p.fs[1] ? ST_LIVE : ST_HOLD;
    end
    if (p.ce[1]) begin
      // Pixel clock: standard rate is half the link clock
      if (p.dc >= half) begin
        next_p.dc   = 3'h0;
        next_p.pclk = ~p.pclk;
        tick        = p.pclk;
      end else begin
        next_p.dc = p.dc + 3'h1;
      end
      next_p.dis = async_shutter_select & p.rp[1];
      // Only an async capture may replay in async mode; others must wait
      if (!async_shutter_select) next_p.got = 1'h0;
      if (!(p.st == ST_EXPOSURE_CONTROL_IN && frz)) next_p.st = base;
      if (async_shutter_select && p.rp[2] && !p.rp[1]) next_p.pend = 1'h1;
      if (frz && p.ex[2] && !p.ex[1]) begin
        next_p.st = ST_EXPOSURE_CONTROL_IN;
      end
      if (p.st == ST_EXPOSURE_CONTROL_IN && frz && !p.ex[2] && p.ex[1]) begin
        next_p.pend = 1'h1;
      end
      if (tick) begin
        next_p.lv   = vid & lnact;
        next_p.fv   = vid & (p.v < V_ACTV);
        next_p.hd   = p.h < H_DRV;
        next_p.vd   = vid & (p.v == '0);
        next_p.data = (vid & lnact) ? (src_mem ? mem_rd : sensor_data_i)
                                    : '0;
        wr = lnact & !src_mem & ((p.st == ST_LIVE) | p.cap);
        if (wr) next_p.have = 1'h1;
        if (lnact) next_p.addr = p.addr + AW'(1);
        if (p.h == H_LAST) begin
          next_p.h = '0;
          // Restart only at a line boundary, keeping horizontal phase
          if (p.pend) begin
            next_p.v    = '0;
            next_p.pend = 1'h0;
            next_p.cap  = 1'h1;
            next_p.have = 1'h1;
            next_p.got  = async_shutter_select;
            next_p.addr = '0;
            next_p.st   = ((!async_shutter_select && !frz) || (frz && p.fs[1])) ? ST_LIVE
                                                            : ST_HOLD;
          end else if (p.v == V_LAST) begin
            next_p.v    = '0;
            next_p.addr = '0;
            next_p.cap  = 1'h0;
          end else begin
            next_p.v = p.v + VW'(1);
          end
        end else begin
          next_p.h = p.h + HW'(1);
        end
      end
      // Blank at once on entering integration rather than at the next pixel
      if (next_p.st == ST_EXPOSURE_CONTROL_IN) begin
        next_p.lv   = 1'h0;
        next_p.fv   = 1'h0;
        next_p.vd   = 1'h0;
        next_p.data = '0;
      end
    end
  end

  always_ff @(posedge pix_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      p    <= '0;
      p.st <= ST_LIVE;
    end else begin
      p <= next_p;
    end
  end

  // Frame store has no reset; contents are valid only once written
  always_ff @(posedge pix_clk_i) begin
    if (wr) begin
      mem[p.addr] <= sensor_data_i;
    end
  end

  assign pixel_clk_o        = p.pclk;
  assign pixel_data_o       = p.data;
  assign line_valid_o       = p.lv;
  assign frame_valid_o      = p.fv;
  assign horizontal_drive_o = p.hd;
  assign vertical_drive_o   = p.vd;
  assign discharge_o        = p.dis;

  // ******************************
  // Assertions
  // ******************************
  a_wait_video_off: assert property (@(posedge pix_clk_i) disable iff (!reset_n_i)
    tick && p.st == ST_WAIT && !p.cap |=> !p.fv && !p.lv)
    else $error("Video active while waiting for async pulse");

  a_fall_arms: assert property (@(posedge pix_clk_i) disable iff (!reset_n_i)
    p.ce[1] && async_shutter_select && p.rp[2] && !p.rp[1] && !p.pend |=> p.pend)
    else $error("Reset falling edge not taken");

  a_async_hold: assert property (@(posedge pix_clk_i) disable iff (!reset_n_i)
    p.ce[1] && async_shutter_select && p.got && p.st != ST_EXPOSURE_CONTROL_IN |=> p.st == ST_HOLD)
    else $error("Stored image not replayed");

  a_normal_live: assert property (@(posedge pix_clk_i) disable iff (!reset_n_i)
    p.ce[1] && !async_shutter_select && !frz |=> p.st == ST_LIVE)
    else $error("Normal shutter not live");

  a_exposure_control_in_quiet: assert property (@(posedge pix_clk_i) disable iff (!reset_n_i)
    tick && p.st == ST_EXPOSURE_CONTROL_IN && !p.cap |=> !p.lv && !p.fv)
    else $error("Valids high during integration");

  a_exposure_control_in_capture: assert property (@(posedge pix_clk_i) disable iff (!reset_n_i)
    p.ce[1] && frz && p.st == ST_EXPOSURE_CONTROL_IN && !p.ex[2] && p.ex[1] |=> p.pend)
    else $error("Integration end not captured");

  a_lv_in_fv: assert property (@(posedge pix_clk_i) disable iff (!reset_n_i)
    p.lv |-> p.fv)
    else $error("Line valid outside frame valid");

  a_vd_with_image: assert property (@(posedge pix_clk_i) disable iff (!reset_n_i)
    p.vd |-> p.fv && p.st != ST_EXPOSURE_CONTROL_IN)
    else $error("Vertical pulse without image");

  a_restart_phase: assert property (@(posedge pix_clk_i) disable iff (!reset_n_i)
    tick && p.pend && p.h == H_LAST |=> p.v == '0 && p.h == '0 && p.cap)
    else $error("Restart broke line phase");

  a_gain_range: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    c.booted |-> c.par.gain >= GAIN_MIN_DB && c.par.gain <= GAIN_MAX_P)
    else $error("Gain outside range");

  a_preset_3dn: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ce_i && c.booted && dn_p && c.mode_s2 == MODE_PRE_LO |=> c.par.gain == PRE_3DN_DB)
    else $error("Preset gain not recalled");

  a_mode0_plain: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ce_i && live |=> c.lvl[1:0] == 2'h0 && c.shut == 4'h0)
    else $error("Mode 0 not plain live");

  c_async_cap: cover property (@(posedge pix_clk_i) disable iff (!reset_n_i)
    async_shutter_select && p.cap && p.lv);
  c_exposure_control_in_cap: cover property (@(posedge pix_clk_i) disable iff (!reset_n_i)
    frz && p.st == ST_EXPOSURE_CONTROL_IN ##[1:1000] p.cap);
  c_hold_play: cover property (@(posedge pix_clk_i) disable iff (!reset_n_i)
    src_mem && p.lv);

endmodule : cvo_capture

//--- verification/cvo_grabber.sv
`timescale 1ns/1ps
// ******************************
// Frame grabber model
// ******************************
module cvo_grabber (
  input  wire logic       pclk_i,
  input  wire logic       lv_i,
  input  wire logic       fv_i,
  input  wire logic [9:0] data_i,
  output int              frames_o,
  output int              lines_o,
  output int              pixels_o,
  output int              stray_o,
  output logic [9:0]      value_o,
  output logic            uniform_o
);
  int         n_lines = 0;
  int         n_pix   = 0;
  logic [9:0] first   = 10'h000;
  logic       same    = 1'b1;
  logic       lv_q    = 1'b0;
  logic       fv_q    = 1'b0;

  initial begin
    frames_o  = 0;
    lines_o   = 0;
    pixels_o  = 0;
    stray_o   = 0;
    value_o   = 10'h000;
    uniform_o = 1'b0;
  end

  // Sampled on the rising edge, away from the launching edge
  always @(posedge pclk_i) begin
    lv_q <= lv_i;
    fv_q <= fv_i;
    if (lv_i && !fv_i) stray_o <= stray_o + 1;
    if (lv_i && fv_i) begin
      n_pix <= n_pix + 1;
      if (n_pix == 0) first <= data_i;
      else if (data_i !== first) same <= 1'b0;
    end
    if (lv_q && !lv_i) n_lines <= n_lines + 1;
    // A frame cut short still counts, so callers skip the first one
    if (fv_q && !fv_i) begin
      frames_o  <= frames_o + 1;
      lines_o   <= n_lines;
      pixels_o  <= n_pix;
      value_o   <= first;
      uniform_o <= same;
      n_lines   <= 0;
      n_pix     <= 0;
      same      <= 1'b1;
    end
  end
endmodule : cvo_grabber

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import cvo_pkg::*;

  // ******************************
  // Signals
  // ******************************
  localparam int HA = 8;
  localparam int VA = 4;

  logic        mclk      = 1'b0;
  logic        pclk      = 1'b0;
  logic        reset_n   = 1'b0;
  logic        async_pin = 1'b1;
  logic        expo_n    = 1'b1;
  logic        fsel      = 1'b0;
  logic [3:0]  mode      = 4'h0;
  logic        up        = 1'b0;
  logic        dn        = 1'b0;
  logic [3:0]  speed     = 4'h3;
  logic [9:0]  scene     = 10'h155;
  wire logic   pixel_clk, lv, fv, hd, vd, disch;
  wire logic [9:0] pdata;
  wire logic [4:0] gain;
  wire logic [3:0] sspd;
  int          frames, lines, pixels, stray;
  logic [9:0]  value;
  logic        uniform;
  int          error_cnt = 0;
  int          checks    = 0;
  logic [3:0]  pm [4] = '{MODE_PRE_HI, MODE_PRE_LO, MODE_PRE_HI, MODE_PRE_LO};
  logic        pu [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic [4:0]  pg [4] = '{PRE_4DN_DB, PRE_3UP_DB, PRE_4UP_DB, PRE_3DN_DB};
  logic        cu [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  real         cp [5] = '{24.0, 48.0, 48.0, 24.0, 12.0};

  initial begin
    forever #2 mclk = ~mclk;
  end
  initial begin
    #1.3;
    forever #3 pclk = ~pclk;
  end

  cvo_capture #(.H_TOTAL_P(80), .V_TOTAL_P(6), .H_ACT_P(HA), .V_ACT_P(VA),
                .GAIN_MAX_P(GAIN_MAX_DB)) u_dut (
    .mclk_i(mclk), .reset_n_i(reset_n), .ce_i(1'b1), .pix_clk_i(pclk),
    .async_reset_pulse_i(async_pin), .exposure_control_in_i(expo_n),
    .freeze_select_i(fsel), .mode_sel_i(mode), .press_up_i(up), .press_down_i(dn),
    .page_store_i(1'b0), .shutter_speed_i(speed), .sensor_data_i(scene),
    .pixel_clk_o(pixel_clk), .pixel_data_o(pdata), .line_valid_o(lv),
    .frame_valid_o(fv), .horizontal_drive_o(hd), .vertical_drive_o(vd),
    .discharge_o(disch), .gain_db_o(gain), .shutter_speed_o(sspd));

  cvo_grabber u_grab (.pclk_i(pixel_clk), .lv_i(lv), .fv_i(fv), .data_i(pdata),
    .frames_o(frames), .lines_o(lines), .pixels_o(pixels), .stray_o(stray),
    .value_o(value), .uniform_o(uniform));

  // ******************************
  // Tasks
  // ******************************
  task chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED at %0t ns: %s", $time, msg);
    end
  endtask : chk

  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  task cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  // Pin held well past the two-stage synchroniser before release
  task press(input logic [3:0] m, input logic dir_up);
    mode = m;
    cyc(4);
    if (dir_up) up = 1'b1;
    else dn = 1'b1;
    cyc(4);
    up = 1'b0;
    dn = 1'b0;
    cyc(4);
  endtask : press

  // First frame after a change may be torn, so the second is judged
  task frame_is(input logic [9:0] v, input string msg);
    int f0;
    int k;
    f0 = frames;
    k = 0;
    while (frames < f0 + 2 && k < 12000) begin
      cyc(1);
      k++;
    end
    chk(k < 12000 && lines == VA && pixels == HA * VA && uniform === 1'b1 && value === v,
        msg);
  endtask : frame_is

  task quiet(input string msg);
    logic seen;
    seen = 1'b0;
    repeat (2000) begin
      cyc(1);
      if (lv !== 1'b0 || fv !== 1'b0 || vd !== 1'b0) seen = 1'b1;
    end
    chk(!seen, msg);
  endtask : quiet

  task period(input real e);
    realtime t0;
    realtime p;
    cyc(40);
    @(posedge pixel_clk);
    @(posedge pixel_clk);
    t0 = $realtime;
    @(posedge pixel_clk);
    p = $realtime - t0;
    chk(p > e - 0.1 && p < e + 0.1, "pixel clock period");
  endtask : period

  task pulse;
    async_pin = 1'b0;
    cyc(10);
    async_pin = 1'b1;
  endtask : pulse

  // ******************************
  // Tests
  // ******************************
  initial begin
    cyc(4);
    reset_n = 1'b1;
    cyc(10);
    chk(gain === GAIN_MIN_DB, "power-up gain");
    frame_is(10'h155, "live frame");
    $display("test power_up_live done");
    for (int i = 0; i < 17; i++) begin
      press(MODE_GAIN, 1'b1);
      chk(gain === ((i < 16) ? 5'(7 + i) : GAIN_MAX_DB), "gain up");
    end
    for (int i = 0; i < 17; i++) begin
      press(MODE_GAIN, 1'b0);
      chk(gain === ((i < 16) ? 5'(21 - i) : GAIN_MIN_DB), "gain down");
    end
    for (int i = 0; i < 4; i++) begin
      press(pm[i], pu[i]);
      chk(gain === pg[i], "gain preset");
    end
    press(MODE_FACTORY, 1'b1);
    chk(gain === GAIN_MIN_DB, "factory recall");
    $display("test gain done");
    period(12.0);
    for (int i = 0; i < 5; i++) begin
      press(MODE_CLOCK, cu[i]);
      period(cp[i]);
    end
    $display("test clock done");
    press(MODE_FREEZE, 1'b0);
    scene = 10'h2aa;
    frame_is(10'h155, "frozen image");
    expo_n = 1'b0;
    scene = 10'h0f0;
    cyc(20);
    quiet("valid during integration");
    expo_n = 1'b1;
    frame_is(10'h0f0, "integrated frame");
    scene = 10'h333;
    frame_is(10'h0f0, "integrated frame held");
    fsel = 1'b1;
    frame_is(10'h333, "live with select high");
    fsel = 1'b0;
    press(MODE_FREEZE, 1'b1);
    scene = 10'h0cc;
    frame_is(10'h0cc, "live after unfreeze");
    $display("test freeze done");
    press(MODE_SHUT, 1'b0);
    cyc(20);
    chk(disch === 1'b1, "discharge while pin high");
    quiet("video off while pin high");
    scene = 10'h1e1;
    pulse();
    frame_is(10'h1e1, "async capture");
    scene = 10'h21e;
    frame_is(10'h1e1, "async replay");
    pulse();
    frame_is(10'h21e, "async new capture");
    chk(sspd === speed, "shutter speed in use");
    press(MODE_SHUT, 1'b1);
    scene = 10'h3c3;
    frame_is(10'h3c3, "manual shutter live");
    $display("test shutter done");
    press(MODE_SHUT, 1'b0);
    mode = MODE_NORMAL;
    scene = 10'h055;
    frame_is(10'h055, "mode zero live");
    chk(sspd === 4'h0, "mode zero shutter off");
    chk(stray == 0, "line valid outside frame");
    $display("test normal done");
    give_verdict();
  end

  // Tests need about 160 us; double that leaves margin
  initial begin
    #320us;
    error_cnt++;
    $display("CHECK FAILED at %0t ns: watchdog expired", $time);
    give_verdict();
  end
endmodule : tb_top
